// ===== afc_chk.sv
// assertion checker for the automatic flow control block
`timescale 1ns/1ps
module afc_chk
   import afc_pkg::*;
(
   input wire logic      hclk,
   input wire logic      hresetn,
   input wire logic      hreadyout,
   input wire logic      hresp,
   input wire rx_frame_t rx_frame,
   input wire logic      full_duplex,
   input wire logic      tx_enable,
   input wire logic      pause_done,
   input wire logic      jam_active,
   input wire logic      pause_req,
   input wire logic      pause_zero
);
   logic [13:0] jam_len;
   // 14 bits covers the longest jam, 15055 cycles
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn) jam_len <= 14'h0;
      else jam_len <= jam_active ? jam_len + 14'h1 : 14'h0;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_jam_end; jam_active ##1 !jam_active; endsequence
   sequence s_pause_start; !pause_req ##1 pause_req && !pause_zero; endsequence

   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus slave not ready or not okay");
   a_jam_full: assert property (full_duplex |=> !jam_active)
      else $error("jam in full duplex");
   a_tx_off: assert property (!tx_enable |=> !jam_active && !pause_req)
      else $error("flow control with transmitter off");
   a_jam_cause: assert property ($rose(jam_active) |-> $past(tx_enable && !full_duplex))
      else $error("jam without half duplex cause");
   a_jam_len: assert property (s_jam_end ##0 $past(tx_enable && !full_duplex) |-> jam_len >= 14'd125 && jam_len <= 14'd15055)
      else $error("jam length out of range");
   a_pause_hold: assert property (pause_req && !pause_done && tx_enable |=> pause_req)
      else $error("pause request dropped early");
   a_pause_drop: assert property (pause_req && pause_done |=> !pause_req)
      else $error("pause request held after done");
   a_zero_stable: assert property (pause_req ##1 pause_req |-> $stable(pause_zero))
      else $error("pause kind changed mid request");
   a_pause_cause: assert property (s_pause_start |-> $past(full_duplex && tx_enable && rx_frame.preamble))
      else $error("pause without full duplex preamble");
endmodule

bind rx_auto_flow_control afc_chk u_chk (.hclk(hclk), .hresetn(hresetn),
   .hreadyout(hreadyout), .hresp(hresp), .rx_frame(rx_frame),
   .full_duplex(full_duplex), .tx_enable(tx_enable), .pause_done(pause_done),
   .jam_active(jam_active), .pause_req(pause_req), .pause_zero(pause_zero));

// ===== afc_consts.svh
// constants for the automatic receive flow control block
`ifndef AFC_CONSTS_SVH
`define AFC_CONSTS_SVH

// -----------------------------------------------------------------------
// register map (byte addresses)
// -----------------------------------------------------------------------
`define FLOW_CONFIG_OFFSET 8'hac
`define AFC_CTRL_OFFSET    8'h00
`define AFC_STATUS_OFFSET  8'h04

// -----------------------------------------------------------------------
// configuration fields
// -----------------------------------------------------------------------
`define TRIGGER_LVL_LSB    16
`define RESUME_LVL_LSB     8
`define AFC_DUR_LSB        4
`define AFC_MULT_BIT       3
`define AFC_BRD_BIT        2
`define AFC_ADD_BIT        1
`define AFC_ANY_BIT        0
`define FLOW_CONFIG_RESET  32'h0000_0000
`define FLOW_CONFIG_WMASK  32'h00ff_ffff

// -----------------------------------------------------------------------
// timing: clock in kHz, durations in ns
// -----------------------------------------------------------------------
`define AFC_CLK_KHZ        25000
`define AFC_EXTRA_10M_NS   2200
`define AFC_UNIT_BYTES_LOG 6
`define JAM_CODE0_NS       5000
`define JAM_CODE1_NS       10000
`define JAM_CODE2_NS       15000
`define JAM_CODE3_NS       25000
`define JAM_STEP_NS        50000
`endif

// ===== afc_pkg.sv
// types shared by the automatic flow control block
package afc_pkg;
   typedef struct packed {
      logic [7:0] fifo_trigger_threshold;
      logic [7:0] fifo_resume_threshold;
      logic [3:0] jam_duration_code;
      logic       trigger_on_multicast;
      logic       trigger_on_broadcast;
      logic       trigger_on_own_address;
      logic       trigger_on_any_frame;
   } auto_flow_control_config_t;

   typedef struct packed {
      logic preamble;
      logic dest_valid;
      logic multicast;
      logic broadcast;
      logic own_address;
   } rx_frame_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_JAM
   } jam_state_t;
endpackage

// ===== afc_tx_model.sv
// transmitter stand-in that answers pause frame requests
`timescale 1ns/1ps
module afc_tx_model (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic pause_req,
   input  wire logic slow,
   output logic      pause_done
);
   logic [3:0] wait_reg;
   // slow mimics a frame already on the wire delaying the pause
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wait_reg   <= 4'h0;
         pause_done <= 1'b0;
      end else if (pause_req && !pause_done && wait_reg == (slow ? 4'h9 : 4'h2)) begin
         wait_reg   <= 4'h0;
         pause_done <= 1'b1;
      end else begin
         wait_reg   <= pause_req && !pause_done ? wait_reg + 4'h1 : 4'h0;
         pause_done <= 1'b0;
      end
   end
endmodule

// ===== rx_auto_flow_control.sv
// automatic receive flow control with ahb-lite configuration slave
//
// Contract
// R1: software keeps resume threshold below trigger threshold
// R2: jam held for programmed duration code time
// R3: duration code ignored in full duplex
// R4: code maps to 5us..600us, plus 2.2us at 10M
// R5: multicast frame at level triggers jam
// R6: broadcast frame at level triggers jam
// R7: own address frame at level triggers jam
// R8: class trigger bits inert in full duplex
// R9: any-frame bit: jam half, pause full duplex
// R10: any-frame acts on preamble, skips address decode
// R11: any-frame bit overrides class trigger bits
// R12: trigger threshold times 64, one pause
// R13: each matching half duplex frame jammed
// R14: below resume threshold send zero pause once
// R15: transmitter disabled blocks pause and jam
// R16: compare fifo count to thresholds every cycle
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "afc_consts.svh"

module rx_auto_flow_control
   import afc_pkg::*;
#(
   parameter int FIFO_CNT_W = 14
) (
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  hsel,
   input  wire logic [7:0]            haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic [31:0]                hrdata,
   input  wire logic [FIFO_CNT_W-1:0] rx_fifo_count,
   input  wire rx_frame_t             rx_frame,
   input  wire logic                  full_duplex,
   input  wire logic                  speed_100,
   input  wire logic                  tx_enable,
   input  wire logic                  pause_done,
   output logic                       jam_active,
   output logic                       pause_req,
   output logic                       pause_zero
);

   // -----------------------------------------------------------------------
   // duration table in ns for 100 Mb/s
   // -----------------------------------------------------------------------
   function automatic int dur_ns(input logic [3:0] code);
      int t;
      t = 0;
      case (code)
         4'h0:    t = `JAM_CODE0_NS;
         4'h1:    t = `JAM_CODE1_NS;
         4'h2:    t = `JAM_CODE2_NS;
         4'h3:    t = `JAM_CODE3_NS;
         4'h4:    t = `JAM_STEP_NS * 1;
         4'h5:    t = `JAM_STEP_NS * 2;
         4'h6:    t = `JAM_STEP_NS * 3;
         4'h7:    t = `JAM_STEP_NS * 4;
         4'h8:    t = `JAM_STEP_NS * 5;
         4'h9:    t = `JAM_STEP_NS * 6;
         4'ha:    t = `JAM_STEP_NS * 7;
         4'hb:    t = `JAM_STEP_NS * 8;
         4'hc:    t = `JAM_STEP_NS * 9;
         4'hd:    t = `JAM_STEP_NS * 10;
         4'he:    t = `JAM_STEP_NS * 11;
         default: t = `JAM_STEP_NS * 12;
      endcase
      return t;
   endfunction

   // all times round down to whole cycles
   function automatic logic [15:0] dur_cycles(input logic [3:0] code,
                                              input logic       fast);
      int ns;
      int cyc;
      ns  = dur_ns(code);
      // slower line adds a fixed tail to every code
      if (!fast) begin
         ns = ns + `AFC_EXTRA_10M_NS;
      end
      cyc = (ns * (`AFC_CLK_KHZ / 1000)) / 1000;
      return 16'(cyc);
   endfunction

   // -----------------------------------------------------------------------
   // ahb-lite slave
   // -----------------------------------------------------------------------
   auto_flow_control_config_t    cfg_reg;
   logic [31:0] cfg_word;
   logic        wr_pend_reg;
   logic [7:0]  wr_addr_reg;
   logic [31:0] rdata_next;
   logic [31:0] status_word;
   logic        hi_reached_reg;
   logic        pause_sent_reg;
   jam_state_t  state_reg;
   logic [15:0] jam_cnt_reg;

   wire addr_phase = hsel & hready & htrans[1];
   wire wr_cfg     = wr_pend_reg & (wr_addr_reg == `FLOW_CONFIG_OFFSET);
   wire wr_pend_next = addr_phase & hwrite;
   wire rd_take      = addr_phase & ~hwrite;

   assign cfg_word = {8'h00, cfg_reg};
   assign status_word = {28'h0000000, pause_sent_reg, hi_reached_reg,
                         pause_req, jam_active};
   assign rdata_next = (haddr == `FLOW_CONFIG_OFFSET) ? cfg_word :
                       (haddr == `AFC_STATUS_OFFSET) ? status_word :
                       32'h0000_0000;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
      end else begin
         wr_pend_reg <= wr_pend_next;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_addr_reg <= 8'h00;
      end else if (addr_phase) begin
         wr_addr_reg <= haddr;
      end
   end

   // read data loaded at the address phase so it stands in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_take) begin
         hrdata <= rdata_next;
      end
   end

   // no wait states and no error response
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
      end else begin
         hreadyout <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_reg <= auto_flow_control_config_t'(24'(`FLOW_CONFIG_RESET));
      end else if (wr_cfg) begin
         cfg_reg <= auto_flow_control_config_t'(hwdata[23:0]);
      end
   end

   // -----------------------------------------------------------------------
   // level compare
   // -----------------------------------------------------------------------
   // thresholds scaled by 64 bytes, evaluated each cycle
   wire [FIFO_CNT_W+7:0] cnt_ext = {8'h00, rx_fifo_count};
   wire [FIFO_CNT_W+7:0] hi_bytes =
      (FIFO_CNT_W+8)'(cfg_reg.fifo_trigger_threshold) << `AFC_UNIT_BYTES_LOG;
   wire [FIFO_CNT_W+7:0] lo_bytes =
      (FIFO_CNT_W+8)'(cfg_reg.fifo_resume_threshold) << `AFC_UNIT_BYTES_LOG;
   wire level_hi = cnt_ext >= hi_bytes; // R16 R12
   wire level_lo = cnt_ext <  lo_bytes; // R16 R14

   // -----------------------------------------------------------------------
   // frame match
   // -----------------------------------------------------------------------
   wire any_mode = cfg_reg.trigger_on_any_frame;
   // class match needs the decoded destination
   wire class_hit = rx_frame.dest_valid &
      ((cfg_reg.trigger_on_multicast   & rx_frame.multicast)  | // R5
       (cfg_reg.trigger_on_broadcast   & rx_frame.broadcast)  | // R6
       (cfg_reg.trigger_on_own_address & rx_frame.own_address)); // R7
   wire any_hit   = any_mode & rx_frame.preamble; // R10
   wire half_hit  = any_mode ? any_hit : class_hit; // R11 R13
   wire jam_start = tx_enable & ~full_duplex & level_hi & half_hit; // R15 R8
   wire afc_on    = |cfg_reg[3:0];
   wire fd_on     = tx_enable & full_duplex & any_mode; // R9 R15 R8

   // -----------------------------------------------------------------------
   // half duplex jam timer
   // -----------------------------------------------------------------------
   wire [15:0] jam_len  = dur_cycles(cfg_reg.jam_duration_code, speed_100);
   // a zero count would wrap for 65536 cycles, so loads floor at one; the shortest jam is 125 cycles
   wire [15:0] jam_load = (jam_len == 16'h0000) ? 16'h0001 : jam_len; // R2 R4
   // full duplex or tx off ends the jam early; code unused there
   wire        jam_abort = full_duplex | ~tx_enable; // R3 R15
   wire        jam_last  = jam_cnt_reg == 16'h0001; // R2

   jam_state_t  state_next;
   logic [15:0] jam_cnt_next;
   logic        jam_active_next;

   always_comb begin
      state_next      = state_reg;
      jam_cnt_next    = jam_cnt_reg;
      jam_active_next = jam_active;
      case (state_reg)
         ST_IDLE: begin
            if (jam_start) begin
               state_next      = ST_JAM;
               jam_cnt_next    = jam_load; // R2 R4
               jam_active_next = 1'b1;
            end
         end
         ST_JAM: begin
            if (jam_abort | jam_last) begin
               state_next      = ST_IDLE;
               jam_active_next = 1'b0;
            end else begin
               jam_cnt_next = jam_cnt_reg - 16'h0001; // R2
            end
         end
         default: begin
            state_next      = ST_IDLE;
            jam_active_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         jam_cnt_reg <= 16'h0000;
      end else begin
         jam_cnt_reg <= jam_cnt_next;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         jam_active <= 1'b0;
      end else begin
         jam_active <= jam_active_next;
      end
   end

   // -----------------------------------------------------------------------
   // full duplex pause requests
   // -----------------------------------------------------------------------
   // one pause per excursion above the trigger level, held till taken
   wire pause_taken = pause_done | ~tx_enable; // R15
   wire pause_hi    = fd_on & ~hi_reached_reg & level_hi & any_hit; // R12 R10
   wire pause_lo    = fd_on & hi_reached_reg & pause_sent_reg & level_lo; // R14

   logic hi_reached_next;
   logic pause_sent_next;
   logic pause_req_next;
   logic pause_zero_next;

   always_comb begin
      hi_reached_next = hi_reached_reg;
      pause_sent_next = pause_sent_reg;
      pause_req_next  = pause_req;
      pause_zero_next = pause_zero;
      if (pause_req) begin
         if (pause_taken) begin
            pause_req_next  = 1'b0;
            pause_sent_next = pause_done & ~pause_zero;
         end
      end else if (pause_hi) begin
         hi_reached_next = 1'b1; // R12 R10
         pause_req_next  = 1'b1;
         pause_zero_next = 1'b0;
      end else if (pause_lo) begin
         hi_reached_next = 1'b0; // R14
         pause_req_next  = 1'b1;
         pause_zero_next = 1'b1;
      end else if (~afc_on) begin
         // dropping every trigger bit forgets the last excursion
         hi_reached_next = 1'b0;
         pause_sent_next = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hi_reached_reg <= 1'b0;
      end else begin
         hi_reached_reg <= hi_reached_next;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pause_sent_reg <= 1'b0;
      end else begin
         pause_sent_reg <= pause_sent_next;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pause_req <= 1'b0;
      end else begin
         pause_req <= pause_req_next;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pause_zero <= 1'b0;
      end else begin
         pause_zero <= pause_zero_next;
      end
   end

endmodule

// ===== test_rx_auto_flow_control.sv
// self-checking bench for automatic receive flow control
`timescale 1ns/1ps
`include "afc_consts.svh"
module test_rx_auto_flow_control import afc_pkg::*;;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic        fd, spd, txen, pdone, preq, pzero, jam, slow;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, rd, d;
   logic [13:0] count;
   rx_frame_t   frame, f;
   int          errors, checks, n;

   rx_auto_flow_control i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .rx_fifo_count(count),
      .rx_frame(frame), .full_duplex(fd), .speed_100(spd),
      .tx_enable(txen), .pause_done(pdone), .jam_active(jam),
      .pause_req(preq), .pause_zero(pzero));
   afc_tx_model u_tx (.hclk(hclk), .hresetn(hresetn), .pause_req(preq),
      .slow(slow), .pause_done(pdone));

   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   initial begin
      #2400000;
      errors++;
      print_verdict();
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task print_verdict();
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   function automatic int jam_cycles(input logic [3:0] c, input logic fast);
      int ns;
      ns = c < 4 ? (c == 3 ? 25000 : 5000 * (c + 1)) : 50000 * (c - 3);
      if (!fast) ns += `AFC_EXTRA_10M_NS;
      return ns * (`AFC_CLK_KHZ / 1000) / 1000;
   endfunction
   // level hi = 64 bytes; frame dropped once jam starts so it cannot rearm
   task jam_case(input logic [7:0] bits, input rx_frame_t fr,
         input logic [13:0] c, input logic [1:0] env, input int want);
      bus(1'b1, `FLOW_CONFIG_OFFSET, {16'h0001, 8'h00, bits});
      count <= c;
      {fd, txen} <= env;
      frame <= fr;
      n = 0;
      while (jam !== 1'b1 && n < 20) begin
         @(posedge hclk);
         n++;
      end
      frame <= '0;
      n = 0;
      while (jam === 1'b1 && n < 16000) begin
         @(posedge hclk);
         n++;
      end
      check(n, want);
   endtask
   task wait_pause(input logic z);
      n = 0;
      while (preq !== 1'b1 && n < 50) begin
         @(posedge hclk);
         n++;
      end
      check({preq, pzero}, {1'b1, z});
      while (preq === 1'b1 && n < 100) begin
         @(posedge hclk);
         n++;
      end
      check(preq, 1'b0);
   endtask

   initial begin
      {hresetn, hsel, hwrite, fd, spd, txen, slow} = '0;
      {htrans, haddr, hwdata, count, frame} = '0;
      hsize = 3'h2;
      errors = 0;
      checks = 0;
      void'($urandom(6));
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, `FLOW_CONFIG_OFFSET, '0);
      check(rd, `FLOW_CONFIG_RESET);
      bus(1'b1, `AFC_STATUS_OFFSET, '1);
      bus(1'b0, `AFC_STATUS_OFFSET, '0);
      check(rd, 32'h0);
      bus(1'b0, `AFC_CTRL_OFFSET, '0);
      check(rd, 32'h0);
      repeat (4) begin
         d = $urandom;
         bus(1'b1, `FLOW_CONFIG_OFFSET, d);
         bus(1'b0, `FLOW_CONFIG_OFFSET, '0);
         check(rd, d & `FLOW_CONFIG_WMASK);
      end
      // classes in turn: any, own, broadcast, multicast
      for (int i = 0; i < 6; i++) begin
         spd <= i[0];
         f = 5'h18 | (i % 4 ? 5'h1 << (i % 4 - 1) : 5'h0);
         jam_case({i[3:0], 4'h1 << (i % 4)}, f, 14'd64, 2'b01,
            jam_cycles(i[3:0], i[0]));
      end
      d = $urandom;
      spd <= d[4];
      jam_case({d[3:0], 4'h9}, 5'h10, 14'd64, 2'b01,
         jam_cycles(d[3:0], d[4]));
      jam_case(8'h08, 5'h1a, 14'd64, 2'b01, 0);
      jam_case(8'h0e, 5'h1c, 14'd63, 2'b01, 0);
      jam_case(8'h3e, 5'h1c, 14'd64, 2'b11, 0);
      jam_case(8'h01, 5'h10, 14'd64, 2'b00, 0);
      bus(1'b1, `FLOW_CONFIG_OFFSET, 32'h0002_0101);
      count <= 14'd128;
      frame <= 5'h10;
      {fd, txen} <= 2'b11;
      wait_pause(1'b0);
      repeat (20) @(posedge hclk);
      check(preq, 1'b0);
      count <= 14'd63;
      slow <= 1'b1;
      wait_pause(1'b1);
      print_verdict();
   end
endmodule
